//--- src/flash_host_pkg.sv
// Constants, command codes and sector decode for the flash bus host
package flash_host_pkg;
    // Clock period of ref_clk_i in ns
    localparam int CLK_NS = 5;
    // Pin timing figures in ns; plain defaults, set them to the fitted part's speed grade
    localparam int ADDRESS_ACCESS_TIME_NS = 70;
    localparam int SELECT_ACCESS_TIME_NS = 70;
    localparam int WRITE_PULSE_NS = 35;
    localparam int RESET_PULSE_MIN_NS = 500;
    localparam int RESET_HIGH_RECOVERY_NS = 50;
    // Least times round up to whole cycles
    localparam int ACCESS_NS = (ADDRESS_ACCESS_TIME_NS > SELECT_ACCESS_TIME_NS) ?
                               ADDRESS_ACCESS_TIME_NS : SELECT_ACCESS_TIME_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_PULSE_MIN_CYC = (RESET_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_HIGH_RECOVERY_CYC = (RESET_HIGH_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_STAGES = 2;
    // Read strobe low time less its spare cycle: access time plus the data synchroniser delay
    localparam int READ_CYC = ACCESS_CYC + SYNC_STAGES;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int SECT_W = 5;
    // Top boot region: A18:A15 all ones, split by A14:A12
    localparam logic [3:0] TOP_REGION = 4'hF;
    localparam logic [SECT_W-1:0] SECT_TOP_32K = 5'h0F;
    localparam logic [SECT_W-1:0] SECT_TOP_8K_A = 5'h10;
    localparam logic [SECT_W-1:0] SECT_TOP_8K_B = 5'h11;
    localparam logic [SECT_W-1:0] SECT_TOP_16K = 5'h12;

    typedef enum logic [1:0] {
        CMD_READ = 2'h0,
        CMD_WRITE = 2'h1,
        CMD_RESET = 2'h2
    } cmd_kind_e;

    // Sector of a word address; byte lane bit is not part of it
    function automatic logic [SECT_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
        logic [SECT_W-1:0] s;
        s = {1'b0, a[18:15]};
        if (a[18:15] == TOP_REGION) begin
            if (!a[14]) begin
                s = SECT_TOP_32K;
            end else if (a[13]) begin
                s = SECT_TOP_16K;
            end else if (a[12]) begin
                s = SECT_TOP_8K_B;
            end else begin
                s = SECT_TOP_8K_A;
            end
        end
        return s;
    endfunction : sector_of
endpackage : flash_host_pkg

//--- src/flash_host.sv
// Host-side bus controller for an asynchronous parallel boot-sector flash
//
// Operation
// - Read: select and gate low, strobe high
// - Write: strobe and select low, gate high
// - Host does not restart an operation aborted by reset; the caller reissues it
// - Wait recovery after reset before reading
`timescale 1ns/10ps
module flash_host (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic [1:0] cmd_kind_i,
    input wire logic [18:0] cmd_addr_i,
    input wire logic cmd_byte_sel_i,
    input wire logic cmd_word_mode_i,
    input wire logic [15:0] cmd_wdata_i,
    output logic rd_valid_o,
    output logic [15:0] rd_data_o,
    output logic busy_o,
    output logic [4:0] sector_o,
    output logic [18:0] flash_addr_o,
    output logic flash_ce_n_o,
    output logic flash_oe_n_o,
    output logic flash_we_n_o,
    output logic flash_reset_n_o,
    output logic flash_byte_n_o,
    output logic [15:0] dq_o,
    output logic [15:0] dq_oe_n_o,
    input wire logic [15:0] dq_i,
    input wire logic ready_busy_n_i
);
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_RD = 7'b0000010,
        S_WSET = 7'b0000100,
        S_WPULSE = 7'b0001000,
        S_HOLD = 7'b0010000,
        S_RST = 7'b0100000,
        S_RREC = 7'b1000000
    } state_e;

    typedef struct packed {
        state_e st;
        logic [flash_host_pkg::CNT_W-1:0] cnt;
        logic [15:0] dq_s1;
        logic [15:0] dq_s2;
        logic rb_s1;
        logic rb_s2;
        logic ready;
        logic rd_valid;
        logic [15:0] rd_data;
        logic [4:0] sector;
        logic [18:0] addr;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rst_n;
        logic byte_n;
        logic [15:0] dq;
        logic [15:0] dq_oe_n;
    } state_s;

    // One spare cycle: the first sync stage must not sample exactly at the access time
    localparam logic [15:0] CNT_READ = 16'(flash_host_pkg::READ_CYC);
    localparam logic [15:0] CNT_WP = 16'(flash_host_pkg::WRITE_PULSE_CYC - 1);
    localparam logic [15:0] CNT_RP = 16'(flash_host_pkg::RESET_PULSE_MIN_CYC - 1);
    localparam logic [15:0] CNT_RH = 16'(flash_host_pkg::RESET_HIGH_RECOVERY_CYC - 1);

    // Power-up issues a hardware reset pulse so the array-read state is certain
    localparam state_s RESET_STATE = '{st: S_RST, cnt: 16'h0000, dq_s1: 16'h0000, dq_s2: 16'h0000,
        rb_s1: 1'b0, rb_s2: 1'b0, ready: 1'b0, rd_valid: 1'b0, rd_data: 16'h0000, sector: 5'h00,
        addr: 19'h00000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0, byte_n: 1'b1,
        dq: 16'h0000, dq_oe_n: 16'hFFFF};

    state_s q;
    state_s d;

    always_comb begin
        d = q;
        d.dq_s1 = dq_i;
        d.dq_s2 = q.dq_s1;
        d.rb_s1 = ready_busy_n_i;
        d.rb_s2 = q.rb_s1;
        d.rd_valid = 1'b0;
        d.cnt = q.cnt + 16'h0001;
        unique case (q.st)
            S_IDLE: begin
                d.ready = 1'b1;
                if (cmd_valid_i && q.ready) begin
                    d.ready = 1'b0;
                    d.cnt = 16'h0000;
                    d.addr = cmd_addr_i;
                    d.byte_n = cmd_word_mode_i;
                    d.sector = flash_host_pkg::sector_of(cmd_addr_i);
                    // Byte mode: on reads and writes the top data line is driven as the byte address bit; a reset floats it
                    d.dq[15] = cmd_word_mode_i ? cmd_wdata_i[15] : cmd_byte_sel_i;
                    d.dq_oe_n[15] = cmd_word_mode_i;
                    d.dq[14:0] = cmd_wdata_i[14:0];
                    unique case (cmd_kind_i)
                        flash_host_pkg::CMD_WRITE: begin
                            d.st = S_WSET;
                            d.ce_n = 1'b0;
                            d.dq_oe_n[7:0] = 8'h00;
                            d.dq_oe_n[14:8] = cmd_word_mode_i ? 7'h00 : 7'h7F;
                            d.dq_oe_n[15] = 1'b0;
                        end
                        flash_host_pkg::CMD_RESET: begin
                            d.st = S_RST;
                            d.rst_n = 1'b0;
                            d.dq_oe_n = 16'hFFFF;
                        end
                        default: begin
                            // Each read starts from deselect, so select access time always applies
                            d.st = S_RD;
                            d.ce_n = 1'b0;
                            d.oe_n = 1'b0;
                            d.dq_oe_n[14:0] = 15'h7FFF;
                        end
                    endcase
                end
            end
            S_RD: begin
                if (q.cnt == CNT_READ) begin
                    d.rd_valid = 1'b1;
                    // Also returns identification codes or status on the low lines
                    d.rd_data = q.byte_n ? q.dq_s2 : {8'h00, q.dq_s2[7:0]};
                    d.ce_n = 1'b1;
                    d.oe_n = 1'b1;
                    d.cnt = 16'h0000;
                    d.st = S_HOLD;
                end
            end
            S_WSET: begin
                d.we_n = 1'b0;
                d.cnt = 16'h0000;
                d.st = S_WPULSE;
            end
            S_WPULSE: begin
                if (q.cnt == CNT_WP) begin
                    d.we_n = 1'b1;
                    d.st = S_HOLD;
                end
            end
            S_HOLD: begin
                // One cycle of data hold, then deselect; a running operation goes on
                d.ce_n = 1'b1;
                d.dq_oe_n = {q.byte_n, 15'h7FFF};
                d.st = S_IDLE;
            end
            S_RST: begin
                if (q.cnt == CNT_RP) begin
                    d.rst_n = 1'b1;
                    d.cnt = 16'h0000;
                    d.st = S_RREC;
                end
            end
            S_RREC: begin
                // Held until recovery elapses and busy has cleared
                if (q.cnt >= CNT_RH && q.rb_s2) begin
                    d.st = S_IDLE;
                end
            end
            default: d = RESET_STATE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    assign cmd_ready_o = q.ready;
    assign rd_valid_o = q.rd_valid;
    assign rd_data_o = q.rd_data;
    assign busy_o = ~q.rb_s2;
    assign sector_o = q.sector;
    assign flash_addr_o = q.addr;
    assign flash_ce_n_o = q.ce_n;
    assign flash_oe_n_o = q.oe_n;
    assign flash_we_n_o = q.we_n;
    assign flash_reset_n_o = q.rst_n;
    assign flash_byte_n_o = q.byte_n;
    assign dq_o = q.dq;
    assign dq_oe_n_o = q.dq_oe_n;

    // Helper counters for pulse widths
    logic [15:0] oe_low_cnt;
    logic [15:0] rst_low_cnt;
    logic [15:0] we_low_cnt;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oe_low_cnt <= 16'h0000;
            rst_low_cnt <= 16'h0000;
            we_low_cnt <= 16'h0000;
        end else begin
            oe_low_cnt <= q.oe_n ? 16'h0000 : oe_low_cnt + 16'h0001;
            rst_low_cnt <= q.rst_n ? 16'h0000 : rst_low_cnt + 16'h0001;
            we_low_cnt <= q.we_n ? 16'h0000 : we_low_cnt + 16'h0001;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    AST_READ_STROBES: assert property (!flash_oe_n_o |-> flash_we_n_o && !flash_ce_n_o)
        else $error("read gate low without select or with write strobe low");
    AST_WRITE_STROBES: assert property (!flash_we_n_o |-> flash_oe_n_o && !flash_ce_n_o)
        else $error("write strobe low without select or with gate low");
    AST_WRITE_DRIVES: assert property (!flash_we_n_o |-> dq_oe_n_o[7:0] == 8'h00)
        else $error("write strobe low while low data lines are not driven");
    AST_NO_CONTENTION: assert property (!flash_oe_n_o |-> dq_oe_n_o[14:0] == 15'h7FFF)
        else $error("host drives data lines while device outputs enabled");
    AST_READ_LENGTH: assert property ($rose(flash_oe_n_o) |-> oe_low_cnt >= 16'(flash_host_pkg::READ_CYC))
        else $error("read strobe shorter than access time");
    AST_WRITE_PULSE: assert property ($rose(flash_we_n_o) |-> we_low_cnt == 16'(flash_host_pkg::WRITE_PULSE_CYC))
        else $error("write pulse width wrong");
    AST_RESET_WIDTH: assert property ($rose(flash_reset_n_o) |-> rst_low_cnt == 16'(flash_host_pkg::RESET_PULSE_MIN_CYC))
        else $error("reset pulse shorter than minimum");
    AST_RESET_RECOVERY: assert property ($rose(flash_reset_n_o) |-> flash_oe_n_o[*8])
        else $error("read started inside reset recovery");
    AST_RESET_FLOATS: assert property (!flash_reset_n_o |-> flash_ce_n_o && flash_we_n_o && dq_oe_n_o == 16'hFFFF)
        else $error("bus active while reset is low");
    AST_BYTE_READ: assert property (rd_valid_o && !flash_byte_n_o |-> rd_data_o[15:8] == 8'h00)
        else $error("byte read returned upper byte");
    AST_BYTE_TOP_LINE: assert property (!flash_byte_n_o && !flash_ce_n_o |-> !dq_oe_n_o[15] && dq_oe_n_o[14:8] == 7'h7F)
        else $error("byte mode top data line not driven as address");
    AST_SECTOR_LOW: assert property (!flash_ce_n_o && flash_addr_o[18:15] != 4'hF |-> sector_o == {1'b0, flash_addr_o[18:15]})
        else $error("sector decode wrong below top region");
    AST_SECTOR_TOP16: assert property (!flash_ce_n_o && flash_addr_o[18:13] == 6'h3F |-> sector_o == 5'h12)
        else $error("top 16K sector decode wrong");
    AST_READ_DONE: assert property ($fell(flash_oe_n_o) |-> ##[1:20] rd_valid_o)
        else $error("read did not complete in time");
endmodule : flash_host

//--- testbench/flash_dev_model.sv
// Behavioural flash device answering the host's pins
`timescale 1ns/10ps
module flash_dev_model #(
    parameter int ACC_NS = 70,
    parameter int BUSY_NS = 400,
    parameter logic [7:0] STAT = 8'h4C
) (
    input wire logic [18:0] addr_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic reset_n_i,
    input wire logic byte_n_i,
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    output logic ready_busy_n_o
);
    logic [15:0] mem [int];
    logic [15:0] w;
    logic [15:0] pd;
    logic [18:0] pa;
    logic [22:0] prev;
    logic we_q = 1'b1;
    logic live = 1'b0;
    int busy = 0;
    int stab = 0;
    initial ready_busy_n_o = 1'b1;
    // Time steps of 1 ns; a released bus inverts its last value every step, so stale data shows on alternate steps
    always #1 begin
        stab = ({addr_i, ce_n_i, oe_n_i, byte_n_i, byte_n_i | dq_i[15]} == prev) ? stab + 1 : 0;
        prev = {addr_i, ce_n_i, oe_n_i, byte_n_i, byte_n_i | dq_i[15]};
        if (!reset_n_i) begin
            live = 1'b0;
            if (busy > 20) busy = 20;
        end else if (we_n_i && !we_q && !ce_n_i && oe_n_i && busy == 0) begin
            pa = addr_i;
            pd = dq_i;
            live = 1'b1;
            busy = BUSY_NS;
        end
        if (busy == 1 && live) mem[pa] = pd;
        if (busy > 0) busy--;
        we_q = we_n_i;
        ready_busy_n_o = (busy == 0);
        w = (busy != 0) ? {8'h00, STAT} : mem.exists(addr_i) ? mem[addr_i] : {addr_i[7:0] ^ 8'hA5, addr_i[15:8]};
        if (!byte_n_i) w = {~dq_o[15:8], (dq_i[15] && busy == 0) ? w[15:8] : w[7:0]};
        dq_o = (!ce_n_i && !oe_n_i && we_n_i && reset_n_i) ? ((stab >= ACC_NS) ? w : ~w) : ~dq_o;
    end
endmodule : flash_dev_model

//--- testbench/tb_top.sv
// Self-checking bench for the flash bus host against a behavioural device
`timescale 1ns/10ps
module tb_top;
    localparam logic [7:0] STAT = 8'h4C;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic [1:0] cmd_kind_i = 2'h0;
    logic [18:0] cmd_addr_i = 19'h00000;
    logic cmd_byte_sel_i = 1'b0;
    logic cmd_word_mode_i = 1'b1;
    logic [15:0] cmd_wdata_i = 16'h0000;
    logic cmd_ready_o, rd_valid_o, busy_o, ce_n, oe_n, we_n, reset_n, byte_n, rb_n;
    logic [15:0] rd_data_o, dq_o, dq_oe_n, dq_dev, dq_wire, got;
    logic [4:0] sector_o;
    logic [18:0] faddr, a;
    logic [15:0] shadow [int];
    logic [18:0] corner [8] = '{19'h77FFF, 19'h78000, 19'h7BFFF, 19'h7C000, 19'h7CFFF, 19'h7D000, 19'h7DFFF, 19'h7E000};
    int miscompares = 0;
    int checked = 0;
    int seed = 32'h3571;
    assign dq_wire = (dq_o & ~dq_oe_n) | (dq_dev & dq_oe_n);
    initial forever #2.5 ref_clk_i = ~ref_clk_i;
    flash_host i_flash_host (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_kind_i(cmd_kind_i), .cmd_addr_i(cmd_addr_i), .cmd_byte_sel_i(cmd_byte_sel_i),
        .cmd_word_mode_i(cmd_word_mode_i), .cmd_wdata_i(cmd_wdata_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .busy_o(busy_o), .sector_o(sector_o), .flash_addr_o(faddr), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
        .flash_we_n_o(we_n), .flash_reset_n_o(reset_n), .flash_byte_n_o(byte_n), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n),
        .dq_i(dq_wire), .ready_busy_n_i(rb_n));
    flash_dev_model #(.STAT(STAT)) i_flash_dev_model (.addr_i(faddr), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .reset_n_i(reset_n), .byte_n_i(byte_n), .dq_i(dq_wire), .dq_o(dq_dev), .ready_busy_n_o(rb_n));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    // Kind 0 ready, 1 read data valid, 2 busy cleared
    task automatic wait_for(input int which, input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            if ((which == 0 && cmd_ready_o === 1'b1) || (which == 1 && rd_valid_o === 1'b1)) break;
            if (which == 2 && busy_o === 1'b0) break;
            @(posedge ref_clk_i) #1;
        end
        if (n == lim) begin
            miscompares++;
            $display("BAD %0t wait ran out", $time);
            test_done();
        end
    endtask : wait_for
    task automatic cmd(input logic [1:0] k, input logic [18:0] ad, input logic bs, input logic wm, input logic [15:0] wd);
        wait_for(0, 400);
        cmd_kind_i = k;
        cmd_addr_i = ad;
        cmd_byte_sel_i = bs;
        cmd_word_mode_i = wm;
        cmd_wdata_i = wd;
        cmd_valid_i = 1'b1;
        @(posedge ref_clk_i) #1;
        cmd_valid_i = 1'b0;
        if (k == 2'h0 || k == 2'h3) wait_for(1, 40);
    endtask : cmd
    function automatic logic [4:0] exp_sect(input logic [18:0] ad);
        if (ad[18:15] != 4'hF) return {1'b0, ad[18:15]};
        if (!ad[14]) return 5'h0F;
        return ad[13] ? 5'h12 : 5'h10 + {4'h0, ad[12]};
    endfunction : exp_sect
    function automatic logic [15:0] exp_rd(input logic [18:0] ad, input logic bs, input logic wm);
        logic [15:0] w;
        w = shadow.exists(ad) ? shadow[ad] : {ad[7:0] ^ 8'hA5, ad[15:8]};
        return wm ? w : {8'h00, bs ? w[15:8] : w[7:0]};
    endfunction : exp_rd
    task automatic rd_chk(input logic [18:0] ad, input logic bs, input logic wm, input logic [15:0] ex);
        cmd(2'h0, ad, bs, wm, 16'h0000);
        check(rd_data_o, ex, "read data");
        check({11'h000, sector_o}, {11'h000, exp_sect(ad)}, "sector");
    endtask : rd_chk
    always @(posedge ref_clk_i) begin
        if (rstn_i && !oe_n) begin
            check({15'h0000, we_n}, 16'h0001, "strobe in read");
            check({1'b0, dq_oe_n[14:0]}, 16'h7FFF, "drive in read");
        end
        if (rstn_i && !we_n) check({14'h0000, ce_n, oe_n}, 16'h0001, "gate in write");
    end
    initial begin
        repeat (8) @(posedge ref_clk_i);
        #1 rstn_i = 1'b1;
        for (int i = 0; i < 8; i++) begin
            a = 19'($random(seed));
            rd_chk(a, i[0], i[1], exp_rd(a, i[0], i[1]));
        end
        foreach (corner[j]) rd_chk(corner[j], j[0], j[1], exp_rd(corner[j], j[0], j[1]));
        // Spare kind code behaves as a plain read
        cmd(2'h3, corner[0], 1'b0, 1'b1, 16'h0000);
        check(rd_data_o, exp_rd(corner[0], 1'b0, 1'b1), "spare kind read");
        a = 19'($random(seed));
        got = 16'($random(seed));
        cmd(2'h1, a, 1'b0, 1'b1, got);
        rd_chk(a, 1'b0, 1'b1, {8'h00, STAT});
        check({15'h0000, busy_o}, 16'h0001, "busy in program");
        wait_for(2, 400);
        shadow[a] = got;
        rd_chk(a, 1'b0, 1'b1, exp_rd(a, 1'b0, 1'b1));
        // Abort a program with a reset pulse, then restart it
        a = a ^ 19'h00100;
        cmd(2'h1, a, 1'b0, 1'b1, ~got);
        cmd(2'h2, a, 1'b0, 1'b1, 16'h0000);
        wait_for(0, 400);
        check({15'h0000, busy_o}, 16'h0000, "busy after reset");
        rd_chk(a, 1'b0, 1'b1, exp_rd(a, 1'b0, 1'b1));
        cmd(2'h1, a, 1'b0, 1'b1, ~got);
        rd_chk(a, 1'b1, 1'b1, {8'h00, STAT});
        wait_for(2, 400);
        shadow[a] = ~got;
        rd_chk(a, 1'b1, 1'b0, exp_rd(a, 1'b1, 1'b0));
        test_done();
    end
endmodule : tb_top
